// File: smrb_defs.vh
// Purpose: offsets, field positions and reset values of the subsystem register bank
// Assumes: byte offsets on a 32-bit internal register port
// Notes: definitions only
`ifndef SMRB_DEFS_VH
`define SMRB_DEFS_VH
`define SMRB_AW 9
`define SMRB_OFF_ERR_ADDR 9'h004
`define SMRB_OFF_ERR_CTRL 9'h014
`define SMRB_OFF_IRQ_CTRL 9'h018
`define SMRB_OFF_TRACE_EN 9'h01c
`define SMRB_OFF_DEBUG_EN 9'h020
`define SMRB_OFF_WATCHDOG_COUNT 9'h028
`define SMRB_OFF_THERM_DIS 9'h040
`define SMRB_OFF_IO_POWER 9'h064
`define SMRB_OFF_VW_SRC 9'h090
`define SMRB_ERR_CTRL_W 2
`define SMRB_ERR_CTRL_RST 2'h0
`define SMRB_IRQ_CTRL_RST 1'h1
`define SMRB_TRACE_RST 1'h0
`define SMRB_DEBUG_W 5
`define SMRB_DEBUG_RST 5'h00
`define SMRB_GEN_RST 32'h00000000
`define SMRB_FLD_ERR_DIS 0
`endif

// File: smrb_reg32.v
// Purpose: one plain read/write register word with system reset
// Assumes: synchronous active-low reset, writes qualified by decode
// Notes: used for the generic configuration words of the bank
module smrb_reg32 #(
    parameter W = 32,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // clock and reset
    input wire core_clk,
    input wire rst_n,
    // write path
    input wire wr_en,
    input wire [W-1:0] wr_data,
    // stored value
    output reg [W-1:0] value_r
);
    always @(posedge core_clk) begin
        if (!rst_n) begin
            value_r <= RST;
        end else if (wr_en) begin
            value_r <= wr_data;
        end
    end
endmodule

// File: smrb_bank.v
// Purpose: miscellaneous register bank of the embedded processor subsystem
// Assumes: one host clock, register port sampled synchronously, one-cycle read latency
// Notes: watchdog event counter has its own reset; no interrupt output exists
//
// Overview of operation
// - all register accesses run on host clock
// - system reset defaults all but watchdog counter
// - watchdog counter cleared by its dedicated reset
// - dedicated reset stays off on watchdog resets
// - bank raises no interrupts
// - accesses still complete while commanded asleep
// - bus error loads address when register zero
// - any write to its word clears address; capture wins
// - later errors ignored while address nonzero
// - registers decoded at base plus offset
`include "smrb_defs.vh"
module smrb_bank (
    // host clock and resets
    input wire core_clk,
    input wire rst_n,
    input wire system_reset_except_watchdog_n,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [`SMRB_AW-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata_r,
    output reg reg_ack_r,
    // power control sleep command
    input wire sleep_req,
    // bus master error report
    input wire bus_err,
    input wire [31:0] bus_err_addr,
    // watchdog event
    input wire watchdog_event,
    // configuration outputs
    output reg mem_exc_disable_r,
    output reg alt_vector_en_r,
    output reg trace_port_en_r,
    output reg [`SMRB_DEBUG_W-1:0] debug_port_en_r
);
    reg [31:0] err_addr_r;
    reg [31:0] err_addr_nxt;
    reg [`SMRB_ERR_CTRL_W-1:0] err_ctrl_r;
    reg [31:0] watchdog_count_r;
    reg [31:0] watchdog_count_nxt;
    wire [31:0] therm_dis;
    wire [31:0] io_power;
    wire [31:0] vw_src;
    wire [31:0] err_ctrl_word;
    wire [31:0] alt_vector_word;
    wire [31:0] trace_word;
    wire [31:0] debug_word;
    reg [31:0] rdata_nxt;
    wire wr_any;
    wire wr_err_addr;
    wire wr_err_ctrl;
    wire wr_irq_ctrl;
    wire wr_trace_en;
    wire wr_debug_en;
    wire wr_watchdog_count;
    wire wr_therm_dis;
    wire wr_io_power;
    wire wr_vw_src;
    wire err_addr_empty;
    wire err_capture;

    // sleep_req is deliberately unused by access logic: the bank stays reachable
    assign wr_any = reg_wr;

    // full-offset compare, so no word aliases into an unlisted offset
    assign wr_err_addr = wr_any && (reg_addr == `SMRB_OFF_ERR_ADDR);
    assign wr_err_ctrl = wr_any && (reg_addr == `SMRB_OFF_ERR_CTRL);
    assign wr_irq_ctrl = wr_any && (reg_addr == `SMRB_OFF_IRQ_CTRL);
    assign wr_trace_en = wr_any && (reg_addr == `SMRB_OFF_TRACE_EN);
    assign wr_debug_en = wr_any && (reg_addr == `SMRB_OFF_DEBUG_EN);
    assign wr_watchdog_count = wr_any && (reg_addr == `SMRB_OFF_WATCHDOG_COUNT);
    assign wr_therm_dis = wr_any && (reg_addr == `SMRB_OFF_THERM_DIS);
    assign wr_io_power = wr_any && (reg_addr == `SMRB_OFF_IO_POWER);
    assign wr_vw_src = wr_any && (reg_addr == `SMRB_OFF_VW_SRC);

    // only the first fault since the last clear is kept
    assign err_addr_empty = (err_addr_r == 32'h00000000);
    assign err_capture = bus_err && err_addr_empty;

    // narrow registers sit in the low bits; the rest reads zero
    assign err_ctrl_word = {{(32-`SMRB_ERR_CTRL_W){1'b0}}, err_ctrl_r};
    assign alt_vector_word = {31'h0, alt_vector_en_r};
    assign trace_word = {31'h0, trace_port_en_r};
    assign debug_word = {{(32-`SMRB_DEBUG_W){1'b0}}, debug_port_en_r};

    // capture is tested first, so it wins over a clearing write in one cycle
    always @* begin
        err_addr_nxt = err_addr_r;
        if (err_capture) begin
            err_addr_nxt = bus_err_addr;
        end else if (wr_err_addr) begin
            err_addr_nxt = 32'h00000000;
        end
    end

    // every process below uses core_clk only
    always @(posedge core_clk) begin
        if (!rst_n) begin
            err_addr_r <= `SMRB_GEN_RST;
        end else begin
            err_addr_r <= err_addr_nxt;
        end
    end

    // writes to unlisted offsets match no strobe and fall away
    always @(posedge core_clk) begin
        if (!rst_n) begin
            err_ctrl_r <= `SMRB_ERR_CTRL_RST;
        end else if (wr_err_ctrl) begin
            err_ctrl_r <= reg_wdata[`SMRB_ERR_CTRL_W-1:0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            alt_vector_en_r <= `SMRB_IRQ_CTRL_RST;
        end else if (wr_irq_ctrl) begin
            alt_vector_en_r <= reg_wdata[0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            trace_port_en_r <= `SMRB_TRACE_RST;
        end else if (wr_trace_en) begin
            trace_port_en_r <= reg_wdata[0];
        end
    end

    always @(posedge core_clk) begin
        if (!rst_n) begin
            debug_port_en_r <= `SMRB_DEBUG_RST;
        end else if (wr_debug_en) begin
            debug_port_en_r <= reg_wdata[`SMRB_DEBUG_W-1:0];
        end
    end

    // extra flop keeps every top output straight from a register
    always @(posedge core_clk) begin
        if (!rst_n) begin
            mem_exc_disable_r <= 1'b0;
        end else begin
            mem_exc_disable_r <= err_ctrl_r[`SMRB_FLD_ERR_DIS];
        end
    end

    // a load from the processor beats an event in the same cycle
    always @* begin
        watchdog_count_nxt = watchdog_count_r;
        if (wr_watchdog_count) begin
            watchdog_count_nxt = reg_wdata;
        end else if (watchdog_event) begin
            watchdog_count_nxt = watchdog_count_r + 32'h00000001;
        end
    end

    // counter survives system reset; only its own reset clears it
    // the reset source keeps that input high on watchdog resets
    always @(posedge core_clk) begin
        if (!system_reset_except_watchdog_n) begin
            watchdog_count_r <= 32'h00000000;
        end else begin
            watchdog_count_r <= watchdog_count_nxt;
        end
    end

    smrb_reg32 #(.W(32), .RST(`SMRB_GEN_RST)) u_therm (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(wr_therm_dis),
        .wr_data(reg_wdata),
        .value_r(therm_dis)
    );
    smrb_reg32 #(.W(32), .RST(`SMRB_GEN_RST)) u_iopwr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(wr_io_power),
        .wr_data(reg_wdata),
        .value_r(io_power)
    );
    smrb_reg32 #(.W(32), .RST(`SMRB_GEN_RST)) u_vwsrc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_en(wr_vw_src),
        .wr_data(reg_wdata),
        .value_r(vw_src)
    );

    always @* begin
        rdata_nxt = 32'h00000000;
        case (reg_addr)
            `SMRB_OFF_ERR_ADDR: rdata_nxt = err_addr_r;
            `SMRB_OFF_ERR_CTRL: rdata_nxt = err_ctrl_word;
            `SMRB_OFF_IRQ_CTRL: rdata_nxt = alt_vector_word;
            `SMRB_OFF_TRACE_EN: rdata_nxt = trace_word;
            `SMRB_OFF_DEBUG_EN: rdata_nxt = debug_word;
            `SMRB_OFF_WATCHDOG_COUNT: rdata_nxt = watchdog_count_r;
            `SMRB_OFF_THERM_DIS: rdata_nxt = therm_dis;
            `SMRB_OFF_IO_POWER: rdata_nxt = io_power;
            `SMRB_OFF_VW_SRC: rdata_nxt = vw_src;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // ack is a one-cycle pulse per access, asleep or not
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_ack_r <= 1'b0;
        end else begin
            reg_ack_r <= reg_rd | reg_wr;
        end
    end

    // read data holds until the next read, so a late look still sees it
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // no interrupt port exists on this bank
endmodule

// File: smrb_chk_checker.sv
// Purpose: port checker for smrb_bank
// Assumes: one clock, rst_n synchronous low
// Notes: bound to every bank instance
module smrb_chk (
    // watched ports
    input logic core_clk, rst_n, reg_wr, reg_rd, reg_ack_r, bus_err,
    input logic [8:0] reg_addr,
    input logic [31:0] reg_wdata, reg_rdata_r,
    input logic mem_exc_disable_r, alt_vector_en_r, trace_port_en_r,
    input logic [4:0] debug_port_en_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ack_one_cycle: assert property ((reg_rd || reg_wr) |=> reg_ack_r)
        else $error("ack late");
    a_ack_has_cause: assert property (reg_ack_r |-> $past(reg_rd || reg_wr))
        else $error("stray ack");
    a_reset_out_defaults: assert property ($rose(rst_n) |-> alt_vector_en_r && !trace_port_en_r
        && debug_port_en_r == 5'h00 && !mem_exc_disable_r) else $error("bad default");
    a_write_clears_addr: assert property (reg_wr && reg_addr == 9'h004 && !bus_err ##1 !bus_err
        ##1 reg_rd && reg_addr == 9'h004 && !bus_err |=> reg_rdata_r == 32'h0) else $error("no clear");
    a_reserved_read_zero: assert property (reg_rd && reg_addr == 9'h038 |=> reg_rdata_r == 32'h0)
        else $error("reserved nonzero");
    a_trace_write: assert property (reg_wr && reg_addr == 9'h01c |=> trace_port_en_r == $past(reg_wdata[0]))
        else $error("trace bit");
    a_debug_write: assert property (reg_wr && reg_addr == 9'h020 |=> debug_port_en_r == $past(reg_wdata[4:0]))
        else $error("debug bits");
    a_exc_lag: assert property (reg_wr && reg_addr == 9'h014 |=> ##1 mem_exc_disable_r == $past(reg_wdata[0], 2))
        else $error("exc bit");
    cover property (bus_err && reg_wr);
    cover property (reg_rd && reg_addr == 9'h028);
    cover property ($rose(rst_n));
endmodule
bind smrb_bank smrb_chk smrb_chk_inst (.*);

// File: smrb_cpu.sv
// Purpose: processor side of the register port
// Assumes: requests launched 1 ns after a rising edge
// Notes: idle address and data show the inverse of the last value
module smrb_cpu (
    input logic core_clk,
    output logic reg_wr, reg_rd,
    output logic [8:0] reg_addr,
    output logic [31:0] reg_wdata,
    input logic [31:0] reg_rdata_r,
    input logic reg_ack_r
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // a write to the error address word clears it unless a bus error capture lands in the same cycle
    task acc(input logic w, input logic [8:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic k);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(posedge core_clk);
        #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
        // ack and read data stand for this whole cycle, so take them now
        {q, k} = {reg_rdata_r, reg_ack_r};
        @(posedge core_clk);
        #1;
    endtask
endmodule

// File: tb_top.sv
// Purpose: self-checking bench for smrb_bank
// Assumes: 100 MHz core_clk
// Notes: model words indexed by offset over four
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, rst_n = 0, system_reset_except_watchdog_n = 0, sleep_req = 0;
    logic bus_err = 0, watchdog_event = 0, k, reg_wr, reg_rd, reg_ack_r;
    logic mem_exc_disable_r, alt_vector_en_r, trace_port_en_r;
    logic [4:0] debug_port_en_r;
    logic [8:0] reg_addr;
    logic [31:0] bus_err_addr = 0, q, reg_wdata, reg_rdata_r, m[0:63];
    logic [8:0] offs[12] = '{9'h000, 9'h004, 9'h008, 9'h014, 9'h018, 9'h01c,
                             9'h020, 9'h028, 9'h038, 9'h040, 9'h064, 9'h090};
    int bad_count = 0, checks = 0;
    always #5 core_clk = ~core_clk;
    smrb_cpu smrb_cpu_inst (.*);
    smrb_bank smrb_bank_inst (.*);
    function automatic logic [31:0] msk(input logic [8:0] a);
        case (a)
            9'h014: return 32'h3;
            9'h018, 9'h01c: return 32'h1;
            9'h020: return 32'h1f;
            9'h028, 9'h040, 9'h064, 9'h090: return 32'hffffffff;
            default: return 32'h0;
        endcase
    endfunction
    task chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [8:0] a, input logic [31:0] d);
        smrb_cpu_inst.acc(1, a, d, q, k);
        chk(k, 1);
        m[a[8:2]] = d & msk(a);
    endtask
    task rdm(input logic [8:0] a);
        smrb_cpu_inst.acc(0, a, 0, q, k);
        chk(k, 1);
        chk(q, m[a[8:2]]);
    endtask
    task err(input logic [31:0] a);
        {bus_err, bus_err_addr} = {1'b1, a};
        @(posedge core_clk);
        #1 {bus_err, bus_err_addr} = {1'b0, ~a};
        if (m[1] == 0) m[1] = a;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #20000 bad_count++;
        complete_run;
    end
    initial begin
        void'($urandom(32'h14e1));
        foreach (m[i]) m[i] = (i == 6);
        repeat (10) @(posedge core_clk);
        #1 {rst_n, system_reset_except_watchdog_n} = 2'b11;
        foreach (offs[j]) rdm(offs[j]);
        $display("reset values done");
        sleep_req = 1;
        foreach (offs[j]) begin
            wr(offs[j], $urandom);
            rdm(offs[j]);
        end
        chk({alt_vector_en_r, trace_port_en_r, debug_port_en_r, mem_exc_disable_r},
            {m[6][0], m[7][0], m[8][4:0], m[5][0]});
        $display("access sweep done");
        err($urandom | 1);
        err($urandom | 2);
        rdm(9'h004);
        wr(9'h004, $urandom);
        rdm(9'h004);
        {bus_err, bus_err_addr} = {1'b1, 32'h80000010};
        wr(9'h004, $urandom);
        m[1] = 32'h80000010;
        {bus_err, bus_err_addr} = {1'b0, 32'h7fffffef};
        rdm(9'h004);
        $display("error capture done");
        wr(9'h028, 32'h5);
        watchdog_event = 1;
        repeat (3) @(posedge core_clk);
        #1 watchdog_event = 0;
        m[10] += 3;
        rst_n = 0;
        @(posedge core_clk);
        #1 rst_n = 1;
        foreach (m[i]) if (i != 10) m[i] = (i == 6);
        rdm(9'h028);
        rdm(9'h018);
        system_reset_except_watchdog_n = 0;
        @(posedge core_clk);
        #1 system_reset_except_watchdog_n = 1;
        m[10] = 0;
        rdm(9'h028);
        $display("watchdog count done");
        complete_run;
    end
endmodule
